// ---- core/lec_top.sv ----
// Purpose: status lamps, alarms, sanity timer, A/B signalling of a lineside E1 card
// Assumes: all pins synchronous to CLK_SYS_I; framer and loop datapath sit outside
// Notes: registers over AXI4-Lite, one outstanding read and one write
`timescale 1ns/10ps
`default_nettype none
module lec_top
  import lec_pkg::*;
#(
  parameter int unsigned SELFTEST_CYC = SELFTEST_MS * MS_CYC,
  parameter int unsigned SANITY_CYC   = SANITY_MS * MS_CYC,
  parameter int unsigned BLINK_CYC    = BLINK_MS * MS_CYC
) (
  // clock and reset
  input  wire logic        CLK_SYS_I,
  input  wire logic        RESET_N_I,
  // axi4-lite slave
  input  wire logic [7:0]  S_AXI_AWADDR_I,
  input  wire logic        S_AXI_AWVALID_I,
  output logic             S_AXI_AWREADY_O,
  input  wire logic [31:0] S_AXI_WDATA_I,
  input  wire logic [3:0]  S_AXI_WSTRB_I,
  input  wire logic        S_AXI_WVALID_I,
  output logic             S_AXI_WREADY_O,
  output logic [1:0]       S_AXI_BRESP_O,
  output logic             S_AXI_BVALID_O,
  input  wire logic        S_AXI_BREADY_I,
  input  wire logic [7:0]  S_AXI_ARADDR_I,
  input  wire logic        S_AXI_ARVALID_I,
  output logic             S_AXI_ARREADY_O,
  output logic [31:0]      S_AXI_RDATA_O,
  output logic [1:0]       S_AXI_RRESP_O,
  output logic             S_AXI_RVALID_O,
  input  wire logic        S_AXI_RREADY_I,
  // slot enables from the shelf controller
  input  wire logic        SLOT0_EN_I,
  input  wire logic        SLOT1_EN_I,
  // link alarm inputs from the framer
  input  wire logic        LOS_I,
  input  wire logic        BER_ALM_I,
  input  wire logic        SLIP_ALM_I,
  input  wire logic        RX_YELLOW_I,
  // switches
  input  wire logic [3:0]  SHELF_ADDR_I,
  input  wire logic [3:0]  CARD_POS_I,
  input  wire logic        SW_GROUND_START_I,
  input  wire logic [1:0]  SW_SCHEME_I,
  input  wire logic        SW_CRC4_I,
  input  wire logic        SW_HDB3_I,
  input  wire logic        SW_FAIL_OFFHOOK_I,
  // received A/B bits per channel from the framer
  input  wire logic [59:0] RX_AB_I,
  // lamps and link controls
  output logic             LED_STATUS_O,
  output logic             LED_RED_O,
  output logic             LED_YELLOW_O,
  output logic             LED_MAINT_O,
  output logic             TX_YELLOW_O,
  output logic             MCU_RESET_O,
  output logic             CRC4_MODE_O,
  output logic             HDB3_MODE_O,
  output logic [59:0]      TX_AB_O,
  output logic [29:0]      HOST_OFFHOOK_O,
  output logic [29:0]      HOST_RING_O,
  output logic [5:0]       MAINT_ADDR_O
);
  // axi slave
  logic        aw_got_r, w_got_r;
  logic [7:0]  aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  logic        bvalid_r, rvalid_r;
  logic [1:0]  bresp_r, rresp_r;
  logic [31:0] rdata_r;
  logic [31:0] ctrl_r, ctrl_nxt;
  logic [29:0] ch_en_r;
  logic        card_en_r;
  logic [29:0] hook_r, ring_r;
  logic        wr_go, rd_go, wr_hit, rd_hit, clr_pulse, kick;
  logic [31:0] rd_mux;
  logic [31:0] wmask;

  assign wr_go = aw_got_r && w_got_r && !bvalid_r;
  assign rd_go = S_AXI_ARVALID_I && !rvalid_r && !S_AXI_ARREADY_O;
  assign wmask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}}, {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
  assign wr_hit = (aw_addr_r == REG_CTRL) || (aw_addr_r == REG_ENABLE) ||
                  (aw_addr_r == REG_SANITY) || (aw_addr_r == REG_HOOK) ||
                  (aw_addr_r == REG_RING);
  assign clr_pulse = wr_go && aw_addr_r == REG_CTRL && w_strb_r[0] && w_data_r[CTL_CLRALM];
  assign kick = wr_go && aw_addr_r == REG_SANITY;
  assign ctrl_nxt = ((ctrl_r & ~wmask) | (w_data_r & wmask)) & ~(32'h1 << CTL_CLRALM);

  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      aw_got_r        <= 1'b0;
      w_got_r         <= 1'b0;
      aw_addr_r       <= 8'h00;
      w_data_r        <= 32'h0000_0000;
      w_strb_r        <= 4'h0;
      bvalid_r        <= 1'b0;
      bresp_r         <= RESP_OKAY;
      S_AXI_AWREADY_O <= 1'b0;
      S_AXI_WREADY_O  <= 1'b0;
    end else begin
      S_AXI_AWREADY_O <= !aw_got_r && !S_AXI_AWREADY_O && S_AXI_AWVALID_I;
      S_AXI_WREADY_O  <= !w_got_r && !S_AXI_WREADY_O && S_AXI_WVALID_I;
      if (S_AXI_AWREADY_O) begin
        aw_got_r  <= 1'b1;
        aw_addr_r <= S_AXI_AWADDR_I;
      end
      if (S_AXI_WREADY_O) begin
        w_got_r  <= 1'b1;
        w_data_r <= S_AXI_WDATA_I;
        w_strb_r <= S_AXI_WSTRB_I;
      end
      if (wr_go) begin
        bvalid_r <= 1'b1;
        bresp_r  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        aw_got_r <= 1'b0;
        w_got_r  <= 1'b0;
      end else if (bvalid_r && S_AXI_BREADY_I) begin
        bvalid_r <= 1'b0;
      end
    end
  end
  assign S_AXI_BVALID_O = bvalid_r;
  assign S_AXI_BRESP_O  = bresp_r;

  // control registers
  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      ctrl_r    <= CTRL_RST;
      ch_en_r   <= '0;
      card_en_r <= 1'b0;
      hook_r    <= '0;
      ring_r    <= '0;
    end else if (wr_go) begin
      if (aw_addr_r == REG_CTRL) ctrl_r <= ctrl_nxt;
      if (aw_addr_r == REG_ENABLE) begin
        ch_en_r   <= w_data_r[29:0];
        card_en_r <= w_data_r[31];
      end
      if (aw_addr_r == REG_HOOK) hook_r <= w_data_r[29:0];
      if (aw_addr_r == REG_RING) ring_r <= w_data_r[29:0];
    end
  end

  // near-end alarm, latched or self-clearing
  logic alm_now, red_r, yel_r;
  assign alm_now = (LOS_I || BER_ALM_I || SLIP_ALM_I) && !ctrl_r[CTL_ALMDIS];
  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      red_r <= 1'b0;
      yel_r <= 1'b0;
    end else begin
      // a new alarm wins over a clear in the same cycle
      if (alm_now) red_r <= 1'b1;
      else if (ctrl_r[CTL_SELFCLR]) red_r <= 1'b0;
      else if (clr_pulse) red_r <= 1'b0;
      yel_r <= RX_YELLOW_I && !ctrl_r[CTL_ALMDIS];
    end
  end

  // status lamp sequencing
  lec_state_type st_r;
  logic [31:0] st_cnt_r;
  logic [2:0]  blink_r;
  logic        blink_on_r, any_en;
  assign any_en = SLOT0_EN_I || SLOT1_EN_I;
  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      st_r       <= ST_TEST;
      st_cnt_r   <= '0;
      blink_r    <= '0;
      blink_on_r <= 1'b0;
    end else begin
      unique case (st_r)
        ST_TEST: begin
          st_cnt_r <= st_cnt_r + 32'd1;
          if (ctrl_r[CTL_STFAIL]) st_r <= ST_FAIL;
          else if (st_cnt_r >= SELFTEST_CYC - 1) begin
            st_r <= ST_BLINK;
            st_cnt_r <= '0;
          end
        end
        ST_BLINK: begin
          st_cnt_r <= st_cnt_r + 32'd1;
          if (st_cnt_r >= BLINK_CYC - 1) begin
            st_cnt_r   <= '0;
            blink_on_r <= !blink_on_r;
            if (blink_on_r) blink_r <= blink_r + 3'd1;
            if (blink_on_r && blink_r == 3'(BLINKS - 1)) st_r <= ST_READY;
          end
        end
        ST_READY: st_r <= ST_READY;
        ST_FAIL:  st_r <= ST_FAIL;
      endcase
    end
  end

  // sanity timer
  logic [31:0] san_r;
  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      san_r       <= '0;
      MCU_RESET_O <= 1'b0;
    end else if (kick) begin
      san_r       <= '0;
      MCU_RESET_O <= 1'b0;
    end else if (san_r >= SANITY_CYC - 1) begin
      san_r       <= '0;
      MCU_RESET_O <= 1'b1;
    end else begin
      san_r       <= san_r + 32'd1;
      MCU_RESET_O <= 1'b0;
    end
  end

  // per-channel A/B signalling and host presentation
  logic        link_fail;
  logic [59:0] tx_ab_nxt;
  logic [29:0] off_nxt, ring_nxt;
  assign link_fail = LOS_I;
  generate
    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
      logic en, a, b;
      // channels below sixteen ride slot 0, the other fourteen slot 1
      assign en = card_en_r && ch_en_r[c] &&
                  ((c < SLOT0_CH) ? SLOT0_EN_I : SLOT1_EN_I);
      // loop start: idle 01, seize 1s; ground start: idle 11, ring 01, seize 1s; s is SW_SCHEME_I[0]
      assign a = en && (hook_r[c] || (SW_GROUND_START_I && !ring_r[c]));
      assign b = !en || !hook_r[c] || (SW_SCHEME_I[0] ^ ring_r[c]);
      assign tx_ab_nxt[2*c+1] = a;
      assign tx_ab_nxt[2*c]   = b;
      assign off_nxt[c]  = link_fail ? SW_FAIL_OFFHOOK_I : (en && RX_AB_I[2*c+1]);
      assign ring_nxt[c] = !link_fail && en && !RX_AB_I[2*c];
    end
  endgenerate

  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      LED_STATUS_O   <= 1'b0;
      LED_RED_O      <= 1'b0;
      LED_YELLOW_O   <= 1'b0;
      LED_MAINT_O    <= 1'b0;
      TX_YELLOW_O    <= 1'b0;
      CRC4_MODE_O    <= 1'b0;
      HDB3_MODE_O    <= 1'b0;
      TX_AB_O        <= '0;
      HOST_OFFHOOK_O <= '0;
      HOST_RING_O    <= '0;
      MAINT_ADDR_O   <= '0;
    end else begin
      unique case (st_r)
        ST_TEST:  LED_STATUS_O <= 1'b1;
        ST_BLINK: LED_STATUS_O <= !blink_on_r;
        ST_READY: LED_STATUS_O <= !any_en;
        ST_FAIL:  LED_STATUS_O <= blink_on_r;
      endcase
      LED_RED_O      <= red_r;
      TX_YELLOW_O    <= red_r;
      LED_YELLOW_O   <= yel_r;
      LED_MAINT_O    <= ctrl_r[CTL_TESTRUN] || ctrl_r[CTL_ALMDIS];
      CRC4_MODE_O    <= SW_CRC4_I;
      HDB3_MODE_O    <= SW_HDB3_I;
      TX_AB_O        <= tx_ab_nxt;
      HOST_OFFHOOK_O <= off_nxt;
      HOST_RING_O    <= ring_nxt;
      MAINT_ADDR_O   <= {SHELF_ADDR_I, CARD_POS_I[1:0]};
    end
  end

  // read side
  always_comb begin
    rd_hit = 1'b1;
    unique case (S_AXI_ARADDR_I)
      REG_CTRL:    rd_mux = ctrl_r;
      REG_STATUS:  rd_mux = {24'h0, st_r, yel_r, red_r, alm_now, MCU_RESET_O};
      REG_ENABLE:  rd_mux = {card_en_r, 1'b0, ch_en_r};
      REG_SANITY:  rd_mux = san_r;
      REG_ID:      rd_mux = {FW_VERSION, CARD_VINTAGE, CARD_TYPE, 2'h0, MAINT_ADDR_O};
      REG_CFG:     rd_mux = {25'h0, SW_FAIL_OFFHOOK_I, SW_HDB3_I, SW_CRC4_I,
                             SW_SCHEME_I, SW_GROUND_START_I, card_en_r};
      REG_ABTX_LO: rd_mux = TX_AB_O[31:0];
      REG_ABTX_HI: rd_mux = {4'h0, TX_AB_O[59:32]};
      REG_HOOK:    rd_mux = {2'h0, hook_r};
      REG_RING:    rd_mux = {2'h0, ring_r};
      default: begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      S_AXI_ARREADY_O <= 1'b0;
      rvalid_r        <= 1'b0;
      rdata_r         <= '0;
      rresp_r         <= RESP_OKAY;
    end else begin
      S_AXI_ARREADY_O <= rd_go;
      if (rd_go) begin
        rvalid_r <= 1'b1;
        rdata_r  <= rd_mux;
        rresp_r  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_r && S_AXI_RREADY_I) begin
        rvalid_r <= 1'b0;
      end
    end
  end
  assign S_AXI_RVALID_O = rvalid_r;
  assign S_AXI_RDATA_O  = rdata_r;
  assign S_AXI_RRESP_O  = rresp_r;
endmodule
`default_nettype wire

// ---- inc/lec_pkg.sv ----
// Purpose: constants and types for the lineside E1 card status and alarm block
// Assumes: 50 MHz system clock, AXI4-Lite register access
package lec_pkg;
  localparam int unsigned CLK_HZ        = 50_000_000;
  localparam int unsigned SELFTEST_MS   = 3000;
  localparam int unsigned SANITY_MS     = 1000;
  localparam int unsigned BLINK_MS      = 250;
  localparam int unsigned MS_CYC        = CLK_HZ / 1000;
  localparam int unsigned NUM_CH        = 30;
  localparam int unsigned SLOT0_CH      = 16;
  localparam int unsigned SLOT1_CH      = 14;
  localparam int unsigned MAX_CARDS     = 64;
  localparam int unsigned BLINKS        = 3;
  // register byte offsets
  localparam logic [7:0] REG_CTRL       = 8'h00;
  localparam logic [7:0] REG_STATUS     = 8'h04;
  localparam logic [7:0] REG_ENABLE     = 8'h08;
  localparam logic [7:0] REG_SANITY     = 8'h0C;
  localparam logic [7:0] REG_ID         = 8'h10;
  localparam logic [7:0] REG_CFG       = 8'h14;
  localparam logic [7:0] REG_ABTX_LO    = 8'h18;
  localparam logic [7:0] REG_ABTX_HI    = 8'h1C;
  localparam logic [7:0] REG_HOOK       = 8'h20;
  localparam logic [7:0] REG_RING       = 8'h24;
  // ctrl bits
  localparam int unsigned CTL_SELFCLR   = 0;
  localparam int unsigned CTL_CLRALM    = 1;
  localparam int unsigned CTL_TESTRUN   = 2;
  localparam int unsigned CTL_ALMDIS    = 3;
  localparam int unsigned CTL_STPASS    = 4;
  localparam int unsigned CTL_STFAIL    = 5;
  localparam logic [31:0] CTRL_RST      = 32'h0000_0001;
  localparam logic [1:0] RESP_OKAY      = 2'h0;
  localparam logic [1:0] RESP_SLVERR    = 2'h2;
  localparam logic [7:0] CARD_TYPE      = 8'h5A; // arbitrary value
  localparam logic [7:0] CARD_VINTAGE   = 8'h01; // arbitrary value
  localparam logic [7:0] FW_VERSION     = 8'h10; // arbitrary value
  typedef enum logic [3:0] {
    ST_TEST  = 4'b0001,
    ST_BLINK = 4'b0010,
    ST_READY = 4'b0100,
    ST_FAIL  = 4'b1000
  } lec_state_type;
endpackage

// ---- tb/lec_monitor.sv ----
// Purpose: port checker for lec_top
// Assumes: short counts from the bench
// Notes: attached by bind in the bench top
`timescale 1ns/10ps
`default_nettype none
module lec_monitor
  import lec_pkg::*;
#(
  parameter int unsigned SANITY_CYC = 50
) (
  // clock and reset
  input wire logic        CLK_SYS_I,
  input wire logic        RESET_N_I,
  // bus write address
  input wire logic [7:0]  S_AXI_AWADDR_I,
  input wire logic        S_AXI_AWVALID_I,
  input wire logic        S_AXI_AWREADY_O,
  // slots, link and switches
  input wire logic        SLOT0_EN_I,
  input wire logic        SLOT1_EN_I,
  input wire logic        LOS_I,
  input wire logic        RX_YELLOW_I,
  input wire logic [3:0]  SHELF_ADDR_I,
  input wire logic [3:0]  CARD_POS_I,
  input wire logic        SW_FAIL_OFFHOOK_I,
  // outputs watched
  input wire logic        LED_STATUS_O,
  input wire logic        LED_RED_O,
  input wire logic        LED_YELLOW_O,
  input wire logic        LED_MAINT_O,
  input wire logic        TX_YELLOW_O,
  input wire logic        MCU_RESET_O,
  input wire logic [29:0] HOST_OFFHOOK_O,
  input wire logic [5:0]  MAINT_ADDR_O
);
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RESET_N_I);
  // cycles since the last kick or timeout; kick seen early, so bounds are loose
  logic [15:0] idle_r;
  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I || MCU_RESET_O || (S_AXI_AWVALID_I && S_AXI_AWREADY_O &&
        S_AXI_AWADDR_I == REG_SANITY)) begin
      idle_r <= '0;
    end else begin
      idle_r <= idle_r + 16'h1;
    end
  end
  sequence s_lit; LED_STATUS_O [*8]; endsequence
  sequence s_slot; (SLOT0_EN_I || SLOT1_EN_I) ##1 (SLOT0_EN_I || SLOT1_EN_I); endsequence
  property p_selftest; $rose(RESET_N_I) && !SLOT0_EN_I && !SLOT1_EN_I |-> ##3 s_lit;
  endproperty
  property p_dark; s_slot |-> !LED_STATUS_O; endproperty
  // lamps trail the alarm input by one latch stage and one output stage
  property p_red; LOS_I |-> ##2 (LED_RED_O || LED_MAINT_O); endproperty
  property p_txy; TX_YELLOW_O == LED_RED_O; endproperty
  property p_yel; RX_YELLOW_I |-> ##2 (LED_YELLOW_O || LED_MAINT_O); endproperty
  property p_san_win;
    MCU_RESET_O |-> idle_r >= SANITY_CYC - 2 && idle_r <= SANITY_CYC + 6;
  endproperty
  property p_san_max; idle_r <= SANITY_CYC + 6; endproperty
  property p_fail_hook; LOS_I ##1 LOS_I && $stable(SW_FAIL_OFFHOOK_I) |->
    HOST_OFFHOOK_O == {30{SW_FAIL_OFFHOOK_I}}; endproperty
  property p_addr; $past(RESET_N_I) && $stable(SHELF_ADDR_I) && $stable(CARD_POS_I) |->
    MAINT_ADDR_O == {SHELF_ADDR_I, CARD_POS_I[1:0]}; endproperty
  a_selftest: assert property (p_selftest) else $error("status lamp dark in self-test");
  a_dark: assert property (p_dark) else $error("status lamp lit with a slot enabled");
  a_red: assert property (p_red) else $error("red lamp dark during link alarm");
  a_txy: assert property (p_txy) else $error("sent yellow does not follow red");
  a_yel: assert property (p_yel) else $error("yellow lamp dark on far yellow");
  a_san_win: assert property (p_san_win) else $error("sanity reset off time");
  a_san_max: assert property (p_san_max) else $error("sanity reset missing");
  a_fail_hook: assert property (p_fail_hook) else $error("hook state wrong on failure");
  a_addr: assert property (p_addr) else $error("maintenance address wrong");
endmodule
`default_nettype wire

// ---- tb/lec_e1_far.sv ----
// Purpose: far-end E1 terminal model
// Assumes: bench sets the alarm causes
// Notes: lost signal garbles the A/B bits
`timescale 1ns/10ps
`default_nettype none
module lec_e1_far (
  // clock and commands
  input wire logic        clk_i,
  input wire logic [2:0]  alm_i,
  input wire logic        yel_i,
  input wire logic [59:0] ab_i,
  // toward the card
  output logic            los_o,
  output logic            ber_o,
  output logic            slip_o,
  output logic            yel_o,
  output logic [59:0]     ab_o
);
  logic [63:0] q_r = '0;
  // no frames while cut, so A/B toggle rather than hold a value
  always @(posedge clk_i) begin
    q_r <= {alm_i, yel_i, alm_i[0] ? ~q_r[59:0] : ab_i};
  end
  assign {los_o, ber_o, slip_o, yel_o, ab_o} = {q_r[61], q_r[62], q_r[63], q_r[60], q_r[59:0]};
endmodule
`default_nettype wire

// ---- tb/lec_top_test.sv ----
// Purpose: self-checking bench for lec_top
// Assumes: shortened counts
// Notes: bench signals carry the port names
`timescale 1ns/10ps
`default_nettype none
module lec_top_test;
  import lec_pkg::*;
  localparam int unsigned ST = 20, BL = 4, SN = 50;
  logic CLK_SYS_I = 0, RESET_N_I = 0, SLOT0_EN_I = 0, SLOT1_EN_I = 0;
  logic [7:0] S_AXI_AWADDR_I = '0, S_AXI_ARADDR_I = '0;
  logic [31:0] S_AXI_WDATA_I = '0, S_AXI_RDATA_O, rdv;
  logic [3:0] S_AXI_WSTRB_I = 4'hF, SHELF_ADDR_I = 4'hA, CARD_POS_I = 4'h2;
  logic S_AXI_AWVALID_I = 0, S_AXI_WVALID_I = 0, S_AXI_BREADY_I = 0;
  logic S_AXI_ARVALID_I = 0, S_AXI_RREADY_I = 0, S_AXI_AWREADY_O, S_AXI_WREADY_O;
  logic S_AXI_BVALID_O, S_AXI_ARREADY_O, S_AXI_RVALID_O;
  logic [1:0] S_AXI_BRESP_O, S_AXI_RRESP_O, rs, SW_SCHEME_I = 2'h1;
  logic SW_GROUND_START_I = 0, SW_CRC4_I = 1, SW_HDB3_I = 0, SW_FAIL_OFFHOOK_I = 1;
  logic LOS_I, BER_ALM_I, SLIP_ALM_I, RX_YELLOW_I, yel = 0;
  logic [2:0] alm = '0;
  logic [59:0] RX_AB_I, TX_AB_O;
  logic LED_STATUS_O, LED_RED_O, LED_YELLOW_O, LED_MAINT_O, TX_YELLOW_O, MCU_RESET_O;
  logic CRC4_MODE_O, HDB3_MODE_O;
  logic [29:0] HOST_OFFHOOK_O, HOST_RING_O;
  logic [5:0] MAINT_ADDR_O;
  int fail_count = 0, comparisons = 0, hits;
  always #10 CLK_SYS_I = ~CLK_SYS_I;
  lec_top #(.SELFTEST_CYC(ST), .SANITY_CYC(SN), .BLINK_CYC(BL)) dut_u (.*);
  lec_e1_far far_u (.clk_i(CLK_SYS_I), .alm_i(alm), .yel_i(yel), .ab_i(60'h0),
    .los_o(LOS_I), .ber_o(BER_ALM_I), .slip_o(SLIP_ALM_I), .yel_o(RX_YELLOW_I),
    .ab_o(RX_AB_I));
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge CLK_SYS_I);
  endtask
  task automatic watch(input int n);
    repeat (n) begin
      @(posedge CLK_SYS_I);
      hits += int'(MCU_RESET_O === 1'b1);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge CLK_SYS_I);
    S_AXI_AWADDR_I <= a;
    S_AXI_WDATA_I <= d;
    S_AXI_AWVALID_I <= 1'b1;
    S_AXI_WVALID_I <= 1'b1;
    S_AXI_BREADY_I <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge CLK_SYS_I);
      if (S_AXI_AWREADY_O) S_AXI_AWVALID_I <= 1'b0;
      if (S_AXI_WREADY_O) S_AXI_WVALID_I <= 1'b0;
      if (S_AXI_BVALID_O) break;
    end
    S_AXI_BREADY_I <= 1'b0;
    if (n == 40) fail_count++;
  endtask
  // answer comes with arready, so the request drops only once rvalid is seen
  task automatic rd(input logic [7:0] a);
    int n;
    @(posedge CLK_SYS_I);
    S_AXI_ARADDR_I <= a;
    S_AXI_ARVALID_I <= 1'b1;
    S_AXI_RREADY_I <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge CLK_SYS_I);
      if (S_AXI_RVALID_O) break;
    end
    S_AXI_ARVALID_I <= 1'b0;
    S_AXI_RREADY_I <= 1'b0;
    rdv = S_AXI_RDATA_O;
    rs = S_AXI_RRESP_O;
    if (n == 40) fail_count++;
  endtask
  task automatic t_boot;
    int f;
    logic p;
    cyc(10);
    chk("lamp in test", LED_STATUS_O, 1);
    p = LED_STATUS_O;
    f = 0;
    repeat (ST + 8 * BL + 10) begin
      @(posedge CLK_SYS_I);
      f += int'(p && !LED_STATUS_O);
      p = LED_STATUS_O;
    end
    chk("blinks", f, 3);
    chk("lamp steady", LED_STATUS_O, 1);
    rd(REG_CTRL);
    chk("ctrl reset", rdv, CTRL_RST);
    $display("boot done");
  endtask
  task automatic t_slots;
    SLOT0_EN_I <= 1'b1;
    cyc(3);
    chk("lamp slot0", LED_STATUS_O, 0);
    SLOT1_EN_I <= 1'b1;
    cyc(1);
    SLOT0_EN_I <= 1'b0;
    cyc(3);
    chk("lamp slot1", LED_STATUS_O, 0);
    SLOT1_EN_I <= 1'b0;
    cyc(3);
    chk("lamp none", LED_STATUS_O, 1);
    $display("slots done");
  endtask
  task automatic t_red;
    for (int k = 0; k < 3; k++) begin
      alm <= 3'h1 << k;
      cyc(4);
      chk("red on", LED_RED_O, 1);
      chk("tx yellow", TX_YELLOW_O, 1);
      if (k == 0) chk("fail hook", HOST_OFFHOOK_O, {30{1'b1}});
      alm <= 3'h0;
      cyc(4);
      chk("red gone", LED_RED_O, 0);
    end
    wr(REG_CTRL, 32'h0);
    alm <= 3'h1;
    cyc(4);
    alm <= 3'h0;
    cyc(6);
    chk("red latched", LED_RED_O, 1);
    wr(REG_CTRL, 32'h2);
    cyc(3);
    chk("red cleared", LED_RED_O, 0);
    wr(REG_CTRL, CTRL_RST);
    $display("red done");
  endtask
  task automatic t_ym;
    yel <= 1'b1;
    cyc(4);
    chk("yellow on", LED_YELLOW_O, 1);
    yel <= 1'b0;
    cyc(4);
    chk("yellow off", LED_YELLOW_O, 0);
    for (int b = CTL_TESTRUN; b <= CTL_ALMDIS; b++) begin
      wr(REG_CTRL, CTRL_RST | (32'h1 << b));
      cyc(3);
      chk("maint on", LED_MAINT_O, 1);
      wr(REG_CTRL, CTRL_RST);
      cyc(3);
      chk("maint off", LED_MAINT_O, 0);
    end
    $display("maint done");
  endtask
  task automatic t_san;
    hits = 0;
    repeat (6) begin
      wr(REG_SANITY, 32'h0);
      watch(SN / 2);
    end
    chk("kicked", hits, 0);
    watch(SN + 10);
    chk("timeout", hits, 1);
    $display("sanity done");
  endtask
  task automatic t_regs;
    rd(REG_ID);
    chk("ident", rdv[31:8], {FW_VERSION, CARD_VINTAGE, CARD_TYPE});
    chk("address", MAINT_ADDR_O, 6'h2A);
    for (int i = 0; i < 2; i++) begin
      SW_CRC4_I <= i[0];
      SW_HDB3_I <= !i[0];
      cyc(3);
      chk("modes", {CRC4_MODE_O, HDB3_MODE_O}, {i[0], !i[0]});
    end
    wr(REG_ENABLE, 32'h8000_0001);
    rd(REG_ENABLE);
    chk("enable", rdv, 32'h8000_0001);
    rd(8'h80);
    chk("unmapped", rs, RESP_SLVERR);
    // channel 0 rides slot 0, so that slot must be up for its A/B bits
    SLOT0_EN_I <= 1'b1;
    wr(REG_HOOK, 32'h1);
    cyc(3);
    chk("a bit", TX_AB_O[1], 1);
    chk("b bit", TX_AB_O[0], 1);
    chk("ring idle", HOST_RING_O[29:1], 64'h0);
    SW_SCHEME_I <= 2'h0;
    cyc(3);
    chk("scheme b", TX_AB_O[0], 0);
    wr(REG_HOOK, 32'h0);
    SW_GROUND_START_I <= 1'b1;
    cyc(3);
    chk("ground start a", TX_AB_O[1], 1);
    SW_GROUND_START_I <= 1'b0;
    cyc(3);
    chk("loop start a", TX_AB_O[1], 0);
    $display("regs done");
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    cyc(8);
    RESET_N_I <= 1'b1;
    t_boot;
    t_slots;
    t_red;
    t_ym;
    t_san;
    t_regs;
    wrap_up;
  end
  initial begin
    cyc(5000);
    fail_count++;
    wrap_up;
  end
endmodule
bind lec_top lec_monitor #(.SANITY_CYC(SANITY_CYC)) mon_u (.*);
`default_nettype wire
